// file: hw/shrp_pkg.sv
// shared constants of the serial host register port
package shrp_pkg;

  // ************************************************************
  // frame layout
  // ************************************************************
  localparam int unsigned INSTR_BITS = 5;    // instruction length
  localparam int unsigned ADDR_BITS  = 11;   // register address length
  localparam int unsigned DATA_BITS  = 8;    // register width
  localparam int unsigned CNT_BITS   = 5;    // bit counter width
  localparam int unsigned DIR_POS    = 4;    // direction bit inside instruction
  localparam logic        DIR_READ   = 1'h1; // msb value selecting a read

  // ************************************************************
  // bit counter milestones
  // ************************************************************
  localparam logic [4:0] CNT_ADDR_END = 5'h10; // instruction + address taken
  localparam logic [4:0] CNT_DATA_END = 5'h18; // write data taken

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    SHRP_IDLE  = 2'b00,
    SHRP_HEAD  = 2'b01,
    SHRP_READ  = 2'b10,
    SHRP_WRITE = 2'b11
  } shrp_state_t;

endpackage

// file: hw/shrp_port.sv
// serial host register port: framed read and write of an internal register array
`timescale 1ns/1ps
module shrp_port
  import shrp_pkg::*;
#(
  parameter int unsigned NUM_REGS = 2048
)
(
  // clock and reset
  input  wire logic CLK_IN,
  input  wire logic RST_B_IN,
  // serial link pins
  input  wire logic CS_B_IN,
  input  wire logic SCLK_IN,
  input  wire logic SERIAL_IN_LINE_IN,
  output logic      SERIAL_OUT_LINE_OUT,
  output logic      SERIAL_OUT_LINE_OE_OUT
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic       sclk_old_q;

  // two flops per pin, plus a third on the link clock for edge detection; only the second stage and that third flop are read
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      meta_q     <= 3'h7;
      sync_q     <= 3'h7;
      // matches the idle-high link clock, so no false rise follows reset
      sclk_old_q <= 1'h1;
    end
    else
    begin
      meta_q     <= {CS_B_IN, SCLK_IN, SERIAL_IN_LINE_IN};
      sync_q     <= meta_q;
      sclk_old_q <= sync_q[1];
    end
  end

  logic cs_b;
  logic sclk_rise;
  logic sclk_fall;
  logic ser_in;
  assign cs_b      = sync_q[2];
  assign ser_in    = sync_q[0];
  assign sclk_rise = sync_q[1] & ~sclk_old_q;
  assign sclk_fall = ~sync_q[1] & sclk_old_q;

  // ************************************************************
  // register storage
  // ************************************************************
  logic [DATA_BITS-1:0] regs_q [NUM_REGS];

  // ************************************************************
  // sequencer
  // ************************************************************
  shrp_state_t              state_q, state_d;
  logic [CNT_BITS-1:0]      cnt_q, cnt_d;
  logic [INSTR_BITS+ADDR_BITS-1:0] head_q, head_d;
  logic [DATA_BITS-1:0]     shift_q, shift_d;
  logic                     out_q, out_d;
  logic                     oe_q, oe_d;
  logic                     wr_en;
  logic [ADDR_BITS-1:0]     addr;

  assign addr = head_q[ADDR_BITS-1:0];

  // next-state: header capture, read shift, write capture
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    head_d  = head_q;
    shift_d = shift_q;
    out_d   = out_q;
    oe_d    = oe_q;
    wr_en   = 1'b0;
    case (state_q)
      SHRP_IDLE:
      begin
        oe_d = 1'b0;
        if (!cs_b)
        begin
          state_d = SHRP_HEAD;
          cnt_d   = '0;
        end
      end
      SHRP_HEAD:
      begin
        if (sclk_rise)
        begin
          head_d = {head_q[INSTR_BITS+ADDR_BITS-2:0], ser_in};
          cnt_d  = cnt_q + 5'h01;
          if (cnt_q + 5'h01 == CNT_ADDR_END)
          begin
            if (head_q[INSTR_BITS+ADDR_BITS-2] == DIR_READ)
            begin
              state_d = SHRP_READ;
              shift_d = regs_q[{head_q[ADDR_BITS-2:0], ser_in}];
            end
            else
              state_d = SHRP_WRITE;
          end
        end
      end
      SHRP_READ:
      begin
        if (sclk_fall)
        begin
          out_d   = shift_q[DATA_BITS-1];
          oe_d    = 1'b1;
          shift_d = {shift_q[DATA_BITS-2:0], 1'b0};
        end
      end
      SHRP_WRITE:
      begin
        // counter freezes past the last data bit, so later bits are ignored
        if (sclk_rise && cnt_q < CNT_DATA_END)
        begin
          shift_d = {shift_q[DATA_BITS-2:0], ser_in};
          cnt_d   = cnt_q + 5'h01;
        end
        else if (cnt_q == CNT_DATA_END)
        begin
          wr_en   = 1'b1;
          cnt_d   = cnt_q + 5'h01;
        end
      end
      default: state_d = SHRP_IDLE;
    endcase
    if (cs_b && state_q != SHRP_IDLE)
    begin
      state_d = SHRP_IDLE;
      oe_d    = 1'b0;
      wr_en   = 1'b0;
    end
  end

  // sequencer registers
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      state_q <= SHRP_IDLE;
      cnt_q   <= '0;
      head_q  <= '0;
      shift_q <= '0;
      out_q   <= 1'b0;
      oe_q    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      head_q  <= head_d;
      shift_q <= shift_d;
      out_q   <= out_d;
      oe_q    <= oe_d;
    end
  end

  // register array write port, at most one store per write frame, none for a frame cut short
  always_ff @(posedge CLK_IN)
  begin
    if (wr_en)
      regs_q[addr] <= shift_q;
  end

  assign SERIAL_OUT_LINE_OUT    = out_q;
  assign SERIAL_OUT_LINE_OE_OUT = oe_q;

  // ************************************************************
  // assertions
  // ************************************************************
  a_release_on_cs: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    cs_b && state_q != SHRP_IDLE |=> !oe_q)
    else $error("serial out still driven after chip select rose");

  a_drive_only_read: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    $rose(oe_q) |-> $past(state_q) == SHRP_READ)
    else $error("serial out driven outside a read");

  a_read_on_msb: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    state_q == SHRP_READ && $past(state_q) == SHRP_HEAD |-> head_q[INSTR_BITS+ADDR_BITS-1] == DIR_READ)
    else $error("read entered with write direction");

  a_write_on_msb: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    state_q == SHRP_WRITE && $past(state_q) == SHRP_HEAD |-> head_q[INSTR_BITS+ADDR_BITS-1] != DIR_READ)
    else $error("write entered with read direction");

  a_extra_bits_ignored: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    state_q == SHRP_WRITE && cnt_q > CNT_DATA_END |=> cnt_q == $past(cnt_q))
    else $error("bits after the write data still counted");

  a_idle_released: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    state_q == SHRP_IDLE |=> !oe_q)
    else $error("serial out driven while no frame is open");

  a_header_length: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    state_q == SHRP_HEAD && state_d != SHRP_HEAD && !cs_b |-> cnt_d == CNT_ADDR_END)
    else $error("header left before 16 bits");

  a_out_on_fall: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    $changed(out_q) |-> $past(sclk_fall) || $past(cs_b))
    else $error("serial out changed off a falling edge");

  a_write_once: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    wr_en |-> cnt_q == CNT_DATA_END ##1 !wr_en)
    else $error("write strobe at wrong bit count");

  a_frame_start: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    state_q == SHRP_IDLE && !cs_b |=> state_q == SHRP_HEAD && cnt_q == '0)
    else $error("frame did not start on chip select low");

endmodule // shrp_port

// file: bench/shrp_host.sv
// serial master model that frames register reads and writes
`timescale 1ns/1ps
module shrp_host
(
  // clock reference
  input  wire logic clk_in,
  // serial link pins
  output logic      cs_b_out,
  output logic      sclk_out,
  output logic      serial_in_line_out,
  input  wire logic serial_out_line_in,
  input  wire logic oe_in
);
  // ************************************************************
  // frame driver
  // ************************************************************
  // idle pins: link clock stands high between frames
  initial
  begin
    cs_b_out = 1'b1;
    sclk_out = 1'b1;
    serial_in_line_out = 1'b0;
  end

  // half link period of 100 ns, ending just after a clock edge
  task automatic half();
    repeat (4) @(posedge clk_in);
    #1;
  endtask

  // one framed access; bits change at the fall, read data sampled before the next fall
  task automatic xfer(input logic rd, input logic [3:0] op, input logic [10:0] adr,
                      input logic [7:0] wd, input int nd, output logic [7:0] got, output int oe_n);
    logic [23:0] fr;
    fr   = {rd, op, adr, wd};
    oe_n = 0;
    got  = 8'h00;
    cs_b_out = 1'b0;
    half();
    for (int i = 23; i >= 8 - nd; i--)
    begin
      sclk_out = 1'b0;
      serial_in_line_out = fr[i];
      half();
      sclk_out = 1'b1;
      half();
      if (i < 8)
      begin
        // a released line shows the inverse of its last value
        got[i] = oe_in ? serial_out_line_in : ~serial_out_line_in;
        oe_n  += int'(oe_in);
      end
    end
    serial_in_line_out = ~serial_in_line_out; // released line shows no stale bit
    half();
    cs_b_out = 1'b1;
    half();
    half();
  endtask
endmodule // shrp_host

// file: bench/test_serial_host_register_port.sv
// self-checking bench of the serial host register port
`timescale 1ns/1ps
module test_serial_host_register_port;
  import shrp_pkg::*;
  // ************************************************************
  // bench signals, model and checks
  // ************************************************************
  logic       clk_in   = 1'b0;
  logic       rst_b_in = 1'b0;
  logic       cs_b, sclk, ser_in, ser_out, oe;
  logic [7:0] got;
  int         oe_n;
  int         error_cnt  = 0;
  int         n_compared = 0;
  logic [7:0] model_q [int];

  // 40 MHz clock
  always #12.5 clk_in = ~clk_in;

  shrp_port i_shrp_port (.CLK_IN(clk_in), .RST_B_IN(rst_b_in), .CS_B_IN(cs_b), .SCLK_IN(sclk),
    .SERIAL_IN_LINE_IN(ser_in), .SERIAL_OUT_LINE_OUT(ser_out), .SERIAL_OUT_LINE_OE_OUT(oe));
  shrp_host i_shrp_host (.clk_in(clk_in), .cs_b_out(cs_b), .sclk_out(sclk), .serial_in_line_out(ser_in),
    .serial_out_line_in(ser_out), .oe_in(oe));

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // counts, verdict, end of run
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence: writes at edge addresses, an aborted write, read back
  initial
  begin
    logic [10:0] adr [8];
    logic [7:0]  wd;
    void'($urandom(49252));
    repeat (4) @(posedge clk_in);
    #1 rst_b_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    check({6'h00, oe, ser_out}, 8'h00);
    adr[0] = 11'h000;
    adr[1] = 11'h7ff;
    for (int i = 2; i < 8; i++)
      adr[i] = 11'($urandom);
    for (int i = 0; i < 8; i++)
    begin
      wd = 8'($urandom);
      i_shrp_host.xfer(1'b0, 4'($urandom), adr[i], wd, 8, got, oe_n);
      model_q[int'(adr[i])] = wd;
      check(8'(oe_n), 8'h00);
    end
    $display("test write burst done");
    i_shrp_host.xfer(1'b0, 4'h0, 11'h000, ~model_q[0], 4, got, oe_n);
    check(8'(oe_n), 8'h00);
    $display("test short write done");
    for (int i = 0; i < 8; i++)
    begin
      i_shrp_host.xfer(1'b1, 4'($urandom), adr[i], 8'($urandom), 8, got, oe_n);
      check(got, model_q[int'(adr[i])]);
      check(8'(oe_n), 8'h08);
      check({7'h00, oe}, 8'h00);
    end
    $display("test read back done");
    print_verdict();
  end

  // watchdog well past the expected 88 us of traffic
  initial
  begin
    #1000000;
    error_cnt++;
    print_verdict();
  end
endmodule // test_serial_host_register_port
